// file: rtl/cbp_bus_ctl.sv
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module cbp_bus_ctl (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // avalon-mm slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // address and cycle definition
  input wire logic [cbp_pkg::ADDR_W-1:0] address_in,
  output logic [cbp_pkg::ADDR_W-1:0] address_out,
  output logic address_oe_out,
  output logic address_strobe_n_out,
  output logic cycle_write_out,
  output logic data_code_out,
  output logic cache_out_n,
  output logic dual_primary_n_out,
  // data and parity
  input wire logic [cbp_pkg::DATA_W-1:0] data_bus_in,
  output logic [cbp_pkg::DATA_W-1:0] data_bus_out,
  output logic data_bus_oe_out,
  input wire logic [cbp_pkg::BYTES-1:0] byte_parity_bus_in,
  output logic [cbp_pkg::BYTES-1:0] byte_parity_bus_out,
  output logic byte_parity_bus_oe_out,
  // system control
  input wire logic burst_ready_n_in,
  input wire logic line_fill_permit_n_in,
  input wire logic bus_error_in_n_in,
  input wire logic clock_halt_request_n_in,
  input wire logic external_address_strobe_n_in,
  input wire logic write_buffer_empty_n_in,
  input wire logic processor_role_strap_in,
  input wire logic second_cpu_enable_n_in,
  output logic second_cpu_enable_n_out,
  output logic second_cpu_enable_n_oe_out,
  output logic machine_check_out,
  output logic float_error_out_n_out
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [cbp_pkg::BYTES-1:0] even_par(input logic [cbp_pkg::DATA_W-1:0] d);
    even_par = '0;
    for (int i = 0; i < cbp_pkg::BYTES; i++) begin
      even_par[i] = ^d[8*i +: 8];
    end
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    be_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        be_merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  // ----------------------------------------
  // register state
  // ----------------------------------------
  cbp_pkg::cbp_state_t state;
  cbp_pkg::cbp_state_t next_state;
  cbp_pkg::cbp_cycle_t cyc;
  cbp_pkg::cbp_cycle_t mc_cap;
  logic [31:0] ctrl;
  logic [31:0] wdata_lo;
  logic [31:0] wdata_hi;
  logic [cbp_pkg::DATA_W-1:0] rdata;
  logic start_pend;
  logic trap;
  logic par_err;
  logic fill_stored;
  logic wb_hold;
  logic role_dual;
  logic second_cpu_enable_n_seen;
  logic in_reset;
  logic err_pend;
  logic [cbp_pkg::ADDR_W-1:cbp_pkg::LINE_LSB] err_line;
  logic [2:0] beats;
  logic [cbp_pkg::ADDR_W-1:0] ctrl_addr;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire bus_req = avs_read_in | avs_write_in;
  wire acc = bus_req & ~avs_waitrequest_out;
  wire wr_acc = acc & avs_write_in;
  wire wr_ctrl = wr_acc && avs_address_in == cbp_pkg::OFS_CTRL;
  wire wr_addr = wr_acc && avs_address_in == cbp_pkg::OFS_ADDR;
  wire wr_wdlo = wr_acc && avs_address_in == cbp_pkg::OFS_WDLO;
  wire wr_wdhi = wr_acc && avs_address_in == cbp_pkg::OFS_WDHI;
  wire wr_stat = wr_acc && avs_address_in == cbp_pkg::OFS_STAT;
  wire [31:0] ctrl_new = be_merge(ctrl, avs_writedata_in, avs_byteenable_in);
  wire [31:0] clr_bits = wr_stat ? (avs_writedata_in & {{24{1'b0}}, {8{avs_byteenable_in[0]}}}) : 32'h0000_0000;
  // a start held back by write ordering still reads as busy, so polling waits for it
  wire [31:0] status = {24'h00_0000, err_pend, second_cpu_enable_n_seen, role_dual, wb_hold, fill_stored, par_err, trap,
                        (state != cbp_pkg::ST_IDLE) | start_pend};
  logic [31:0] rd_mux;
  always_comb begin
    if (avs_address_in == cbp_pkg::OFS_CTRL) begin
      rd_mux = ctrl;
    end else if (avs_address_in == cbp_pkg::OFS_ADDR) begin
      rd_mux = cyc.addr;
    end else if (avs_address_in == cbp_pkg::OFS_WDLO) begin
      rd_mux = wdata_lo;
    end else if (avs_address_in == cbp_pkg::OFS_WDHI) begin
      rd_mux = wdata_hi;
    end else if (avs_address_in == cbp_pkg::OFS_STAT) begin
      rd_mux = status;
    end else if (avs_address_in == cbp_pkg::OFS_MCA) begin
      rd_mux = mc_cap.addr;
    end else if (avs_address_in == cbp_pkg::OFS_MCC) begin
      rd_mux = {28'h000_0000, mc_cap.write, mc_cap.data_cyc, mc_cap.cacheable, mc_cap.excl};
    end else if (avs_address_in == cbp_pkg::OFS_RDLO) begin
      rd_mux = rdata[31:0];
    end else if (avs_address_in == cbp_pkg::OFS_RDHI) begin
      rd_mux = rdata[63:32];
    end else begin
      // unmapped words read as zero, writes are dropped
      rd_mux = 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // cycle engine decode
  // ----------------------------------------
  wire burst_ready_n = ~burst_ready_n_in;
  wire halt = ~clock_halt_request_n_in;
  wire bus_err = ~bus_error_in_n_in;
  wire snoop = ~external_address_strobe_n_in;
  // exclusive writes wait while external writes are still pending
  wire blocked = ctrl[cbp_pkg::CB_WRITE] & ctrl[cbp_pkg::CB_EXCL] & wb_hold;
  wire launch = start_pend & ~blocked & ~in_reset;
  // cacheable cycles burst, the rest are single transfers
  wire [2:0] need = cyc.cacheable ? cbp_pkg::BURST_BEATS : cbp_pkg::SINGLE_BEATS;
  wire last_beat = (state == cbp_pkg::ST_DATA) && burst_ready_n && beats == need - 3'h1;
  wire [cbp_pkg::DATA_W-1:0] wdata = {wdata_hi, wdata_lo};
  wire read_beat = (state == cbp_pkg::ST_DATA) && burst_ready_n && !cyc.write;
  wire snoop_same = snoop && address_in[cbp_pkg::ADDR_W-1:cbp_pkg::LINE_LSB] == err_line;
  wire [cbp_pkg::ADDR_W-1:0] err_addr = (state != cbp_pkg::ST_IDLE) ? cyc.addr : address_in;

  always_comb begin
    case (state)
      cbp_pkg::ST_IDLE: next_state = launch ? cbp_pkg::ST_ADDR : cbp_pkg::ST_IDLE;
      cbp_pkg::ST_ADDR: next_state = cbp_pkg::ST_DATA;
      cbp_pkg::ST_DATA: next_state = last_beat ? cbp_pkg::ST_IDLE : cbp_pkg::ST_DATA;
      default: next_state = cbp_pkg::ST_IDLE;
    endcase
  end

  wire next_t1 = next_state == cbp_pkg::ST_ADDR;
  wire next_busy = next_state != cbp_pkg::ST_IDLE;
  wire next_t2 = next_state == cbp_pkg::ST_DATA;

  // ----------------------------------------
  // avalon slave: one wait state per access
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
      avs_readdata_out <= rd_mux;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl <= cbp_pkg::CTRL_RST;
      wdata_lo <= 32'h0000_0000;
      wdata_hi <= 32'h0000_0000;
      start_pend <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= ctrl_new & ~(32'h0000_0001 << cbp_pkg::CB_START);
      end
      if (wr_wdlo) begin
        wdata_lo <= be_merge(wdata_lo, avs_writedata_in, avs_byteenable_in);
      end
      if (wr_wdhi) begin
        wdata_hi <= be_merge(wdata_hi, avs_writedata_in, avs_byteenable_in);
      end
      // a start while a cycle runs or waits is ignored
      if (wr_ctrl && ctrl_new[cbp_pkg::CB_START] && state == cbp_pkg::ST_IDLE && !start_pend) begin
        start_pend <= 1'b1;
      end else if (launch && state == cbp_pkg::ST_IDLE) begin
        start_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // bus cycle outputs, all registered
  // ----------------------------------------
  // pins launched and sampled on rising clock
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= cbp_pkg::ST_IDLE;
      cyc <= '0;
      beats <= 3'h0;
      address_out <= '0;
      address_oe_out <= 1'b0;
      address_strobe_n_out <= 1'b1;
      cycle_write_out <= 1'b0;
      data_code_out <= 1'b0;
      cache_out_n <= 1'b1;
      data_bus_out <= '0;
      data_bus_oe_out <= 1'b0;
      byte_parity_bus_out <= '0;
      byte_parity_bus_oe_out <= 1'b0;
    end else begin
      state <= next_state;
      if (state == cbp_pkg::ST_IDLE && launch) begin
        cyc <= '{addr: ctrl_addr, write: ctrl[cbp_pkg::CB_WRITE], data_cyc: ctrl[cbp_pkg::CB_DATA],
                 cacheable: ctrl[cbp_pkg::CB_CACHE], excl: ctrl[cbp_pkg::CB_EXCL]};
      end
      beats <= (state == cbp_pkg::ST_DATA && burst_ready_n) ? beats + 3'h1 : (next_t2 ? beats : 3'h0);
      // cycle definition and address appear with the strobe
      address_strobe_n_out <= ~next_t1;
      address_oe_out <= next_busy;
      address_out <= next_t1 ? ctrl_addr : address_out;
      cycle_write_out <= next_t1 ? ctrl[cbp_pkg::CB_WRITE] : cycle_write_out;
      data_code_out <= next_t1 ? ctrl[cbp_pkg::CB_DATA] : data_code_out;
      // cache pin low for cacheable read or writeback burst
      cache_out_n <= next_busy ? ~(next_t1 ? ctrl[cbp_pkg::CB_CACHE] : cyc.cacheable) : 1'b1;
      // write data owns the bus only in the second state
      // byte 0 is lines 7..0; burst writes repeat the one staged quadword
      data_bus_oe_out <= next_t2 & cyc.write;
      data_bus_out <= wdata;
      // even parity leaves in the same clock as the data
      byte_parity_bus_oe_out <= next_t2 & cyc.write;
      byte_parity_bus_out <= even_par(wdata);
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_addr <= '0;
    end else if (wr_addr) begin
      ctrl_addr <= be_merge(ctrl_addr, avs_writedata_in, avs_byteenable_in);
    end
  end

  // ----------------------------------------
  // read data, parity check, fill and write ordering
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata <= '0;
      par_err <= 1'b0;
      fill_stored <= 1'b0;
      wb_hold <= 1'b0;
    end else begin
      // read data taken in the burst ready clock
      if (read_beat) begin
        rdata <= data_bus_in;
      end
      // parity mismatch is flagged; set wins over software clear
      par_err <= (read_beat && even_par(data_bus_in) != byte_parity_bus_in) | (par_err & ~clr_bits[cbp_pkg::SB_PAR]);
      // fill kept only with cache pin active and permit low
      if (last_beat && !cyc.write) begin
        fill_stored <= cyc.cacheable & ~line_fill_permit_n_in;
      end
      // sampled with each issued write, released when empty
      if (!address_strobe_n_out && cycle_write_out && write_buffer_empty_n_in) begin
        wb_hold <= 1'b1;
      end else if (!write_buffer_empty_n_in) begin
        wb_hold <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // bus error and machine check
  // ----------------------------------------
  wire machine_fault_trap_enable = ctrl[cbp_pkg::CB_MCE];
  wire trap_now = (bus_err & machine_fault_trap_enable & ~halt) | (err_pend & ~halt);
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mc_cap <= '0;
      trap <= 1'b0;
      err_pend <= 1'b0;
      err_line <= '0;
      machine_check_out <= 1'b0;
    end else begin
      // latch address and control of the failing cycle
      if (bus_err) begin
        mc_cap <= '{addr: err_addr, write: cyc.write, data_cyc: cyc.data_cyc, cacheable: cyc.cacheable, excl: cyc.excl};
      end
      // deferred while halted; a later snoop to that line loses it
      if (bus_err && machine_fault_trap_enable && halt) begin
        err_pend <= 1'b1;
        err_line <= err_addr[cbp_pkg::ADDR_W-1:cbp_pkg::LINE_LSB];
      end else if (!halt || (err_pend && snoop_same)) begin
        err_pend <= 1'b0;
      end
      // trap taken only with the enable bit set
      trap <= trap_now | (trap & ~clr_bits[cbp_pkg::SB_TRAP]);
      machine_check_out <= trap_now | (trap & ~clr_bits[cbp_pkg::SB_TRAP]);
    end
  end

  // ----------------------------------------
  // role, dual enable, ownership, float error
  // ----------------------------------------
  logic second_cpu_enable_n_drive;
  always_ff @(posedge clock_in) begin
    // no async reset so the strap reaches the pin while reset is held
    second_cpu_enable_n_drive <= sys_rst_in & processor_role_strap_in;
  end
  assign second_cpu_enable_n_oe_out = second_cpu_enable_n_drive;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      in_reset <= 1'b1;
      role_dual <= 1'b0;
      second_cpu_enable_n_seen <= 1'b0;
      second_cpu_enable_n_out <= 1'b0;
      dual_primary_n_out <= 1'b1;
      float_error_out_n_out <= 1'b1;
    end else begin
      // strap and partner enable caught at the first edge after release
      if (in_reset) begin
        role_dual <= processor_role_strap_in;
        second_cpu_enable_n_seen <= ~processor_role_strap_in & ~second_cpu_enable_n_in;
      end
      in_reset <= 1'b0;
      second_cpu_enable_n_out <= 1'b0;
      // primary low while owning the bus; dual parks high
      dual_primary_n_out <= role_dual | ~next_busy;
      // the dual never raises float error
      float_error_out_n_out <= ~(ctrl[cbp_pkg::CB_FPERR] & ~role_dual);
    end
  end

endmodule

// file: inc/cbp_pkg.sv
package cbp_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int BYTES = 8;
  localparam int LINE_LSB = 5;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_ADDR = 6'h04;
  localparam logic [5:0] OFS_WDLO = 6'h08;
  localparam logic [5:0] OFS_WDHI = 6'h0C;
  localparam logic [5:0] OFS_STAT = 6'h10;
  localparam logic [5:0] OFS_MCA = 6'h14;
  localparam logic [5:0] OFS_MCC = 6'h18;
  localparam logic [5:0] OFS_RDLO = 6'h1C;
  localparam logic [5:0] OFS_RDHI = 6'h20;

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int CB_START = 0;
  localparam int CB_WRITE = 1;
  localparam int CB_DATA = 2;
  localparam int CB_CACHE = 3;
  localparam int CB_EXCL = 4;
  localparam int CB_MCE = 5;
  localparam int CB_FPERR = 6;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // ----------------------------------------
  // status fields
  // ----------------------------------------
  localparam int SB_BUSY = 0;
  localparam int SB_TRAP = 1;
  localparam int SB_PAR = 2;
  localparam int SB_FILL = 3;
  localparam int SB_HOLD = 4;
  localparam int SB_DUAL = 5;
  localparam int SB_SECOND_CPU_ENABLE_N = 6;
  localparam int SB_PEND = 7;

  // ----------------------------------------
  // cycle lengths
  // ----------------------------------------
  localparam logic [2:0] BURST_BEATS = 3'h4;
  localparam logic [2:0] SINGLE_BEATS = 3'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b100
  } cbp_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic data_cyc;
    logic cacheable;
    logic excl;
  } cbp_cycle_t;

endpackage

// file: test/cbp_bus_ctl_assertions.sv
`timescale 1ns/1ps
module cbp_bus_ctl_chk (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // cycle pins
  input wire logic address_oe_out,
  input wire logic address_strobe_n_out,
  input wire logic cycle_write_out,
  input wire logic data_code_out,
  input wire logic cache_out_n,
  input wire logic dual_primary_n_out,
  input wire logic [cbp_pkg::DATA_W-1:0] data_bus_out,
  input wire logic data_bus_oe_out,
  input wire logic [cbp_pkg::BYTES-1:0] byte_parity_bus_out,
  input wire logic byte_parity_bus_oe_out,
  // system pins
  input wire logic burst_ready_n_in,
  input wire logic processor_role_strap_in,
  input wire logic second_cpu_enable_n_oe_out,
  input wire logic float_error_out_n_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic in_data;
  logic [2:0] beats;
  logic [7:0] even_par;
  assign in_data = address_oe_out && address_strobe_n_out;
  always_comb begin
    for (int i = 0; i < 8; i++) even_par[i] = ^data_bus_out[8*i+:8];
  end
  // counted from the strobe so a missed or extra beat shows up
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) beats <= 3'h0;
    else if (!address_strobe_n_out) beats <= 3'h0;
    else if (in_data && !burst_ready_n_in) beats <= beats + 3'h1;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_cycle_length: assert property (in_data && !burst_ready_n_in &&
    beats == (cache_out_n ? 3'h0 : 3'h3) |=> !address_oe_out) else $error("cycle too long");
  a_beat_limit: assert property (in_data |-> beats < (cache_out_n ? 3'h1 : 3'h4))
    else $error("beat count over");
  a_par_even: assert property (data_bus_oe_out |-> byte_parity_bus_oe_out &&
    byte_parity_bus_out == even_par) else $error("bad write parity");
  a_write_drive: assert property (!address_strobe_n_out && cycle_write_out |=> data_bus_oe_out)
    else $error("write data late");
  a_type_hold: assert property (!address_strobe_n_out |=> address_oe_out &&
    $stable(cycle_write_out) && $stable(data_code_out)) else $error("cycle type moved");
  a_own_low: assert property (!processor_role_strap_in |-> dual_primary_n_out == !address_oe_out)
    else $error("ownership pin wrong");
  a_dual_own: assert property (processor_role_strap_in |-> dual_primary_n_out)
    else $error("dual drove ownership");
  a_dual_fperr: assert property (processor_role_strap_in |-> float_error_out_n_out)
    else $error("dual float error");
  a_enable_off: assert property (!$past(sys_rst_in) |-> !second_cpu_enable_n_oe_out)
    else $error("enable driven after reset");
  c_write: cover property (!address_strobe_n_out && cycle_write_out);
  c_burst: cover property (in_data && beats == 3'h3);
  c_dual: cover property (processor_role_strap_in && !address_strobe_n_out);
endmodule

bind cbp_bus_ctl cbp_bus_ctl_chk u_chk (
  .clock_in, .sys_rst_in, .address_oe_out, .address_strobe_n_out, .cycle_write_out, .data_code_out,
  .cache_out_n, .dual_primary_n_out, .data_bus_out, .data_bus_oe_out, .byte_parity_bus_out,
  .byte_parity_bus_oe_out, .burst_ready_n_in, .processor_role_strap_in, .second_cpu_enable_n_oe_out,
  .float_error_out_n_out
);

// file: test/cbp_chipset_model.sv
`timescale 1ns/1ps
module cbp_chipset_model (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // device cycle
  input wire logic address_strobe_n_in,
  input wire logic address_oe_in,
  input wire logic [63:0] data_bus_in,
  input wire logic [7:0] byte_parity_bus_in,
  // scenario controls
  input wire logic [1:0] slow_in,
  input wire logic bad_parity_in,
  // answers and observations
  output logic burst_ready_n_out,
  output logic [63:0] data_bus_out,
  output logic [7:0] byte_parity_bus_out,
  output logic [2:0] beats_out,
  output logic [63:0] wdata_out,
  output logic [7:0] wpar_out
);
  logic [1:0] gap;
  logic [63:0] rd;
  function automatic logic [7:0] even_of(input logic [63:0] d);
    for (int i = 0; i < 8; i++) even_of[i] = ^d[8*i+:8];
  endfunction
  assign rd = 64'h0123_4567_89AB_CDE0 | {61'h0, beats_out};
  assign data_bus_out = burst_ready_n_out ? ~rd : rd;
  assign byte_parity_bus_out = burst_ready_n_out ? ~even_of(rd) : even_of(rd) ^ {7'h00, bad_parity_in};
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      burst_ready_n_out <= 1'b1;
      beats_out <= 3'h0;
      gap <= 2'h0;
    end else if (!address_strobe_n_in) begin
      burst_ready_n_out <= 1'b1;
      beats_out <= 3'h0;
      gap <= slow_in;
    end else if (!burst_ready_n_out) begin
      burst_ready_n_out <= 1'b1;
      beats_out <= beats_out + 3'h1;
      wdata_out <= data_bus_in;
      wpar_out <= byte_parity_bus_in;
      gap <= slow_in;
    end else if (address_oe_in && gap != 2'h0) begin
      gap <= gap - 2'h1;
    end else if (address_oe_in) begin
      burst_ready_n_out <= 1'b0;
    end
  end
endmodule

// file: test/tb_cbp_bus_ctl.sv
`timescale 1ns/1ps
module tb_cbp_bus_ctl;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [5:0] avs_address_in = 6'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] snoop_addr = 32'h0;
  logic line_fill_permit_n_in = 1'b0;
  logic bus_error_in_n_in = 1'b1;
  logic clock_halt_request_n_in = 1'b1;
  logic external_address_strobe_n_in = 1'b1;
  logic write_buffer_empty_n_in = 1'b0;
  logic processor_role_strap_in = 1'b0;
  logic partner_en_n = 1'b0;
  logic [1:0] slow = 2'h0;
  logic bad_par = 1'b0;
  logic [31:0] avs_readdata_out, address_out, addr_bus;
  logic avs_waitrequest_out, address_oe_out, address_strobe_n_out, cycle_write_out, data_code_out;
  logic cache_out_n, dual_primary_n_out, data_bus_oe_out, byte_parity_bus_oe_out, burst_ready_n_n, cpu_en_n;
  logic second_cpu_enable_n_out, second_cpu_enable_n_oe_out, machine_check_out, float_error_out_n_out;
  logic [63:0] dut_data, mdl_data, bus_data, wdata;
  logic [7:0] dut_par, mdl_par, bus_par, wpar;
  logic [2:0] beats;
  int fails = 0;
  int checks_done = 0;
  assign addr_bus = address_oe_out ? address_out : snoop_addr;
  assign bus_data = data_bus_oe_out ? dut_data : mdl_data;
  assign bus_par = byte_parity_bus_oe_out ? dut_par : mdl_par;
  assign cpu_en_n = second_cpu_enable_n_oe_out ? second_cpu_enable_n_out : partner_en_n;
  always #50 clock_in = ~clock_in;
  cbp_bus_ctl u_dut (
    .clock_in, .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in(4'hF), .avs_readdata_out, .avs_waitrequest_out, .address_in(addr_bus), .address_out,
    .address_oe_out, .address_strobe_n_out, .cycle_write_out, .data_code_out, .cache_out_n, .dual_primary_n_out,
    .data_bus_in(bus_data), .data_bus_out(dut_data), .data_bus_oe_out, .byte_parity_bus_in(bus_par),
    .byte_parity_bus_out(dut_par), .byte_parity_bus_oe_out, .burst_ready_n_in(burst_ready_n_n), .line_fill_permit_n_in,
    .bus_error_in_n_in, .clock_halt_request_n_in, .external_address_strobe_n_in, .write_buffer_empty_n_in,
    .processor_role_strap_in, .second_cpu_enable_n_in(cpu_en_n), .second_cpu_enable_n_out,
    .second_cpu_enable_n_oe_out, .machine_check_out, .float_error_out_n_out
  );
  cbp_chipset_model u_agent (
    .clock_in, .sys_rst_in, .address_strobe_n_in(address_strobe_n_out), .address_oe_in(address_oe_out),
    .data_bus_in(bus_data), .byte_parity_bus_in(bus_par), .slow_in(slow), .bad_parity_in(bad_par),
    .burst_ready_n_out(burst_ready_n_n), .data_bus_out(mdl_data), .byte_parity_bus_out(mdl_par),
    .beats_out(beats), .wdata_out(wdata), .wpar_out(wpar)
  );
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // request held until the edge that sees waitrequest low
  task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge clock_in);
    while (avs_waitrequest_out !== 1'b0 && n < 20) begin
      n++;
      @(posedge clock_in);
    end
    q = avs_readdata_out;
    cmp({63'h0, n < 20}, 64'h1, "bus answer");
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask
  task automatic cmp_reg(input logic [5:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    cmp({32'h0, q}, {32'h0, exp}, what);
  endtask
  task automatic wait_idle;
    logic [31:0] q;
    q = 32'h1;
    for (int i = 0; i < 30 && q[0] !== 1'b0; i++) av(1'b0, cbp_pkg::OFS_STAT, 32'h0, q);
  endtask
  task automatic do_reset(input logic strap);
    sys_rst_in <= 1'b1;
    processor_role_strap_in <= strap;
    repeat (8) @(posedge clock_in);
    cmp({62'h0, second_cpu_enable_n_oe_out, second_cpu_enable_n_out}, {62'h0, strap, 1'b0}, "enable pin");
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    @(posedge clock_in);
    do_reset(1'b0);
    cmp_reg(cbp_pkg::OFS_STAT, 32'h40, "status after reset");
    cmp_reg(cbp_pkg::OFS_CTRL, cbp_pkg::CTRL_RST, "control reset");
    cmp_reg(6'h3C, 32'h0, "unmapped read");
    wr(cbp_pkg::OFS_ADDR, 32'h0000_1000);
    wr(cbp_pkg::OFS_WDLO, 32'h0000_00FF);
    wr(cbp_pkg::OFS_WDHI, 32'h0300_0001);
    wr(cbp_pkg::OFS_CTRL, 32'h07);
    wait_idle();
    cmp(wdata, 64'h0300_0001_0000_00FF, "write data");
    cmp({56'h0, wpar}, 64'h10, "write parity");
    cmp({61'h0, beats}, 64'h1, "write beats");
    for (int c = 0; c < 2; c++) begin
      slow <= 2'(2 * c);
      wr(cbp_pkg::OFS_CTRL, 32'h05 | (32'(c) << 3));
      wait_idle();
      cmp({61'h0, beats}, c ? 64'h4 : 64'h1, "read beats");
      cmp_reg(cbp_pkg::OFS_RDLO, 32'h89AB_CDE0 | (c ? 32'h3 : 32'h0), "read low");
      cmp_reg(cbp_pkg::OFS_RDHI, 32'h0123_4567, "read high");
      cmp_reg(cbp_pkg::OFS_STAT, c ? 32'h48 : 32'h40, "fill status");
    end
    bad_par <= 1'b1;
    wr(cbp_pkg::OFS_CTRL, 32'h05);
    wait_idle();
    bad_par <= 1'b0;
    cmp_reg(cbp_pkg::OFS_STAT, 32'h44, "parity flagged");
    wr(cbp_pkg::OFS_STAT, 32'h04);
    cmp_reg(cbp_pkg::OFS_STAT, 32'h40, "parity cleared");
    write_buffer_empty_n_in <= 1'b1;
    wr(cbp_pkg::OFS_CTRL, 32'h07);
    wait_idle();
    cmp_reg(cbp_pkg::OFS_STAT, 32'h50, "hold set");
    wr(cbp_pkg::OFS_CTRL, 32'h17);
    repeat (10) @(posedge clock_in);
    cmp_reg(cbp_pkg::OFS_STAT, 32'h51, "exclusive write held");
    write_buffer_empty_n_in <= 1'b0;
    wait_idle();
    cmp_reg(cbp_pkg::OFS_STAT, 32'h40, "held write done");
    for (int m = 0; m < 2; m++) begin
      wr(cbp_pkg::OFS_CTRL, 32'(m) << 5);
      snoop_addr <= 32'h0000_2040 + 32'(m);
      bus_error_in_n_in <= 1'b0;
      @(posedge clock_in);
      bus_error_in_n_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      cmp_reg(cbp_pkg::OFS_MCA, 32'h0000_2040 + 32'(m), "captured address");
      cmp({63'h0, machine_check_out}, 64'(m), "trap output");
      cmp_reg(cbp_pkg::OFS_STAT, m ? 32'h42 : 32'h40, "trap status");
      wr(cbp_pkg::OFS_STAT, 32'h02);
    end
    clock_halt_request_n_in <= 1'b0;
    bus_error_in_n_in <= 1'b0;
    external_address_strobe_n_in <= 1'b0;
    @(posedge clock_in);
    bus_error_in_n_in <= 1'b1;
    external_address_strobe_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    cmp_reg(cbp_pkg::OFS_STAT, 32'hC0, "error deferred");
    clock_halt_request_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    cmp_reg(cbp_pkg::OFS_STAT, 32'h42, "error taken after halt");
    wr(cbp_pkg::OFS_CTRL, 32'h40);
    repeat (2) @(posedge clock_in);
    cmp({63'h0, float_error_out_n_out}, 64'h0, "float error primary");
    do_reset(1'b1);
    wr(cbp_pkg::OFS_CTRL, 32'h40);
    repeat (2) @(posedge clock_in);
    cmp({63'h0, float_error_out_n_out}, 64'h1, "float error dual");
    stop_test();
  end
  // whole sequence needs about two hundred cycles
  initial begin
    #2000000;
    fails++;
    $display("wrong value at %0t: run hung", $time);
    stop_test();
  end
endmodule
